// File: src/dcf_cfg.svh
// dcf_cfg.svh: addresses, field positions, reset values and timing figures of the
// channel function configuration bank. Included by the package file only; the top module has no include of its own.
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

`define DCF_ADDR_W 8
`define DCF_DATA_W 16
`define DCF_CODE_W 10

`define DCF_ADDR_GAIN 8'h03
`define DCF_ADDR_FUNC0 8'h12
`define DCF_ADDR_CMP 8'h17
`define DCF_RST_VAL 16'h0000

`define DCF_GAIN_MSB 12
`define DCF_GAIN_LSB 10
`define DCF_CMPM_MSB 11
`define DCF_CMPM_LSB 10
`define DCF_CLR_BIT 15
`define DCF_SYNC_BIT 14
`define DCF_BRD_BIT 13
`define DCF_PH_MSB 12
`define DCF_PH_LSB 11
`define DCF_SHP_MSB 10
`define DCF_SHP_LSB 8
`define DCF_GEO_BIT 7
`define DCF_STEP_MSB 6
`define DCF_STEP_LSB 4
`define DCF_RATE_MSB 3
`define DCF_RATE_LSB 0

`define DCF_CODE_ZERO 10'h000
`define DCF_CODE_MID 10'h200
`define DCF_RATE_NONE 4'h0

// geometric step kept with 5 fraction bits so 1/32 growth is exact
`define DCF_FRAC_W 5
`define DCF_GSTEP_W 15
`define DCF_GSTEP_ONE 15'h0020

// step intervals in ns, converted to mclk cycles
`define DCF_MCLK_PERIOD_NS 4
`define DCF_CNT_W 22
`define DCF_CYC(ns) ((ns) / `DCF_MCLK_PERIOD_NS)
`define DCF_T01_NS 4000
`define DCF_T02_NS 8000
`define DCF_T03_NS 12000
`define DCF_T04_NS 18000
`define DCF_T05_NS 27040
`define DCF_T06_NS 40480
`define DCF_T07_NS 60720
`define DCF_T08_NS 91120
`define DCF_T09_NS 136720
`define DCF_T10_NS 239200
`define DCF_T11_NS 418640
`define DCF_T12_NS 732560
`define DCF_T13_NS 1282000
`define DCF_T14_NS 2564000
`define DCF_T15_NS 5127920

`endif

// File: src/dcf_pkg.sv
// dcf_pkg: types shared by the channel function configuration bank.
// assumes dcf_cfg.svh is on the include path.
`include "dcf_cfg.svh"

package dcf_pkg;
   typedef enum logic {
      DCF_IDLE = 1'b0,
      DCF_SLEW = 1'b1
   } dcf_slew_state_t;

   typedef enum logic [1:0] {
      DCF_CMP_PLAIN = 2'b00,
      DCF_CMP_HYST = 2'b01,
      DCF_CMP_WINDOW = 2'b10,
      DCF_CMP_BAD = 2'b11
   } dcf_cmp_mode_t;

   typedef enum logic [2:0] {
      DCF_WAVE_TRI = 3'b000,
      DCF_WAVE_SAW = 3'b001,
      DCF_WAVE_ISAW = 3'b010,
      DCF_WAVE_SINE = 3'b100,
      DCF_WAVE_OFF = 3'b111
   } dcf_shape_t;
endpackage : dcf_pkg

// File: src/dcf_top.sv
// dcf_top: configuration bank for gain, comparator threshold mode and channel 0
// functions, plus the channel 0 update/clear/slew engine and channel 1 comparator.
// assumes register commands arrive from the serial port decoder on mclk; only
// load_trigger is asynchronous.
`timescale 1ns/1ps

module dcf_top
   import dcf_pkg::*;
#(
   parameter logic [`DCF_CNT_W-1:0] STEP_CYC [16] = '{
      `DCF_CNT_W'(1), // no-slew code, count unused
      `DCF_CNT_W'(`DCF_CYC(`DCF_T01_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T02_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T03_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T04_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T05_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T06_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T07_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T08_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T09_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T10_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T11_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T12_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T13_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T14_NS)),
      `DCF_CNT_W'(`DCF_CYC(`DCF_T15_NS))
   }
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [`DCF_ADDR_W-1:0] reg_addr,
   input wire logic [`DCF_DATA_W-1:0] reg_wdata,
   output logic [`DCF_DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic ch0_code_wr,
   input wire logic [`DCF_CODE_W-1:0] ch0_code,
   input wire logic bcast_wr,
   input wire logic [`DCF_CODE_W-1:0] bcast_code,
   input wire logic trigger_bit_wr,
   input wire logic load_trigger,
   input wire logic clear_req,
   input wire logic comparator_enable,
   input wire logic ch1_enable,
   input wire logic [`DCF_CODE_W-1:0] cmp_sample,
   input wire logic [`DCF_CODE_W-1:0] thr_upper,
   input wire logic [`DCF_CODE_W-1:0] thr_lower,
   output logic [2:0] current_output_gain,
   output logic [1:0] comparator_threshold_mode,
   output logic [1:0] waveform_phase_select,
   output logic [2:0] waveform_shape_select,
   output logic [`DCF_CODE_W-1:0] ch0_out_code,
   output logic ch0_slewing,
   output logic cmp_out
);

   // all state below freezes while ce is low, synchroniser included, so a
   // paused clock domain never sees a half-taken command

   logic [2:0] gain_q;
   logic [1:0] cmpm_q;
   logic [`DCF_DATA_W-1:0] func_q;
   logic [`DCF_DATA_W-1:0] rdata_q;
   logic rvalid_q;
   logic ldt_s1_q;
   logic ldt_s2_q;
   logic ldt_s3_q;
   logic [`DCF_CODE_W-1:0] staged_q;
   logic [`DCF_CODE_W-1:0] tgt_q;
   logic [`DCF_CODE_W-1:0] out_q;
   logic [`DCF_CNT_W-1:0] cnt_q;
   logic [`DCF_GSTEP_W-1:0] gstep_q;
   dcf_slew_state_t st_q;
   logic cmp_q;

   // step size decode, used by both slew directions
   function automatic logic [`DCF_CODE_W-1:0] lin_step(input logic [2:0] sel);
      logic [`DCF_CODE_W-1:0] s;
      s = `DCF_CODE_W'(1);
      unique case (sel)
         3'h0: s = `DCF_CODE_W'(1);
         3'h1: s = `DCF_CODE_W'(2);
         3'h2: s = `DCF_CODE_W'(3);
         3'h3: s = `DCF_CODE_W'(4);
         3'h4: s = `DCF_CODE_W'(6);
         3'h5: s = `DCF_CODE_W'(8);
         3'h6: s = `DCF_CODE_W'(16);
         3'h7: s = `DCF_CODE_W'(32);
      endcase
      return s;
   endfunction : lin_step

   // move toward target by delta, landing on it instead of overshooting
   function automatic logic [`DCF_CODE_W-1:0] approach(input logic [`DCF_CODE_W-1:0] cur,
         input logic [`DCF_CODE_W-1:0] tgt, input logic [`DCF_CODE_W-1:0] delta);
      logic [`DCF_CODE_W-1:0] r;
      r = tgt;
      if (cur < tgt) begin
         if ((tgt - cur) > delta) r = cur + delta;
      end else if ((cur - tgt) > delta) begin
         r = cur - delta;
      end
      return r;
   endfunction : approach

   // invalid encodings are stored as written; the host owns legality, so the
   // decoders downstream must tolerate them
   // register decode
   wire hit_gain = (reg_addr == `DCF_ADDR_GAIN);
   wire hit_func = (reg_addr == `DCF_ADDR_FUNC0);
   wire hit_cmp = (reg_addr == `DCF_ADDR_CMP);
   wire [`DCF_DATA_W-1:0] gain_view = `DCF_DATA_W'({gain_q, `DCF_CODE_W'(0)});
   wire [`DCF_DATA_W-1:0] cmp_view = `DCF_DATA_W'({cmpm_q, `DCF_CODE_W'(0)});
   wire [`DCF_DATA_W-1:0] rd_mux = hit_gain ? gain_view :
                                   hit_func ? func_q :
                                   hit_cmp ? cmp_view : `DCF_RST_VAL;

   // function fields
   wire clr_mid = func_q[`DCF_CLR_BIT];
   wire deferred = func_q[`DCF_SYNC_BIT];
   wire brd_en = func_q[`DCF_BRD_BIT];
   wire geo_en = func_q[`DCF_GEO_BIT];
   wire [2:0] step_sel = func_q[`DCF_STEP_MSB:`DCF_STEP_LSB];
   wire [3:0] rate_sel = func_q[`DCF_RATE_MSB:`DCF_RATE_LSB];

   // a trigger in the same cycle as a deferred write takes the new code, so the
   // staged copy is never one write behind
   // update sources, clear first, then broadcast, trigger, direct write
   wire ldt_fall = ldt_s3_q & ~ldt_s2_q;
   wire do_bcast = bcast_wr & brd_en;
   wire do_trig = deferred & (ldt_fall | trigger_bit_wr);
   wire do_write = ch0_code_wr & ~deferred;
   wire [`DCF_CODE_W-1:0] trig_code = ch0_code_wr ? ch0_code : staged_q;
   wire [`DCF_CODE_W-1:0] clr_code = clr_mid ? `DCF_CODE_MID : `DCF_CODE_ZERO;
   wire new_tgt = do_bcast | do_trig | do_write;
   wire [`DCF_CODE_W-1:0] tgt_d = do_bcast ? bcast_code :
                                  do_trig ? trig_code : ch0_code;

   // the counter restarts on every new target, so a rapid series of writes can
   // starve the step tick; the last target always wins
   // geometric step keeps fraction bits so the 1/32 growth stays exact
   // slew timing and step
   wire tick = (cnt_q >= (STEP_CYC[rate_sel] - `DCF_CNT_W'(1)));
   wire rising = (out_q < tgt_q);
   wire [`DCF_CODE_W-1:0] gint = `DCF_CODE_W'(gstep_q >> `DCF_FRAC_W);
   wire [`DCF_CODE_W-1:0] gdelta = (gint == `DCF_CODE_ZERO) ? `DCF_CODE_W'(1) : gint;
   wire [`DCF_GSTEP_W-1:0] ginc = gstep_q >> `DCF_FRAC_W;
   wire [`DCF_GSTEP_W-1:0] gstep_d = rising ? gstep_q + ginc : gstep_q - ginc;
   wire [`DCF_CODE_W-1:0] delta = geo_en ? gdelta : lin_step(step_sel);
   wire [`DCF_CODE_W-1:0] out_step = (rate_sel == `DCF_RATE_NONE) ? tgt_q :
                                     approach(out_q, tgt_q, delta);

   // thresholds come straight from the channel 1 margin codes; mode 11 holds
   // the last result so a bad write cannot glitch cmp_out
   // comparator decisions
   wire cmp_active = comparator_enable & ch1_enable;
   wire above = (cmp_sample > thr_upper);
   wire below = (cmp_sample < thr_lower);
   logic cmp_d;
   always_comb begin
      cmp_d = cmp_q;
      unique case (dcf_cmp_mode_t'(cmpm_q))
         DCF_CMP_PLAIN: cmp_d = above;
         DCF_CMP_HYST: cmp_d = above ? 1'b1 : (below ? 1'b0 : cmp_q);
         DCF_CMP_WINDOW: cmp_d = ~above & ~below;
         default: cmp_d = cmp_q;
      endcase
   end

   // writes with ce low are dropped, not queued; the port decoder must hold
   // its strobe until ce returns
   // register bank
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         gain_q <= 3'h0;
         cmpm_q <= 2'h0;
         func_q <= `DCF_RST_VAL;
      end else if (ce && reg_wr) begin
         if (hit_gain) gain_q <= reg_wdata[`DCF_GAIN_MSB:`DCF_GAIN_LSB];
         if (hit_cmp) cmpm_q <= reg_wdata[`DCF_CMPM_MSB:`DCF_CMPM_LSB];
         if (hit_func) func_q <= reg_wdata;
      end
   end

   // read port; unmapped addresses read zero
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         rdata_q <= `DCF_RST_VAL;
         rvalid_q <= 1'b0;
      end else if (ce) begin
         rvalid_q <= reg_rd;
         if (reg_rd) rdata_q <= rd_mux;
      end
   end

   // presets to the idle high level so releasing reset is not a falling edge;
   // logic reads only the second flop and the edge-history flop
   // load trigger pin synchroniser and edge history
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         ldt_s1_q <= 1'b1;
         ldt_s2_q <= 1'b1;
         ldt_s3_q <= 1'b1;
      end else if (ce) begin
         ldt_s1_q <= load_trigger;
         ldt_s2_q <= ldt_s1_q;
         ldt_s3_q <= ldt_s2_q;
      end
   end

   // staged code for deferred updates; every code write lands here, so a
   // trigger with nothing new replays the last one
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         staged_q <= `DCF_CODE_ZERO;
      end else if (ce && ch0_code_wr) begin
         staged_q <= ch0_code;
      end
   end

   // channel 0 target, output and slew engine
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tgt_q <= `DCF_CODE_ZERO;
         out_q <= `DCF_CODE_ZERO;
         cnt_q <= '0;
         gstep_q <= `DCF_GSTEP_ONE;
         st_q <= DCF_IDLE;
      end else if (ce) begin
         if (clear_req) begin
            // clear is immediate and cancels any slew in progress
            tgt_q <= clr_code;
            out_q <= clr_code;
            st_q <= DCF_IDLE;
         end else if (new_tgt) begin
            tgt_q <= tgt_d;
            cnt_q <= '0;
            gstep_q <= `DCF_GSTEP_ONE;
            st_q <= DCF_SLEW;
         end else begin
            unique case (st_q)
               DCF_IDLE: cnt_q <= '0;
               DCF_SLEW: begin
                  if (out_q == tgt_q) begin
                     st_q <= DCF_IDLE;
                  end else if (tick || rate_sel == `DCF_RATE_NONE) begin
                     out_q <= out_step;
                     cnt_q <= '0;
                     if (geo_en) gstep_q <= gstep_d;
                  end else begin
                     cnt_q <= cnt_q + `DCF_CNT_W'(1);
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cmp_q <= 1'b0;
      end else if (ce) begin
         cmp_q <= cmp_active ? cmp_d : 1'b0;
      end
   end

   // every output is a flop; these assigns only rename, so no decode glitch
   // ever reaches a pin
   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign current_output_gain = gain_q;
   assign comparator_threshold_mode = cmpm_q;
   assign waveform_phase_select = func_q[`DCF_PH_MSB:`DCF_PH_LSB];
   assign waveform_shape_select = func_q[`DCF_SHP_MSB:`DCF_SHP_LSB];
   assign ch0_out_code = out_q;
   assign ch0_slewing = st_q;
   assign cmp_out = cmp_q;

endmodule : dcf_top

// File: bench/dcf_host.sv
// dcf_host: host model that issues register writes and reads to the bank.
// assumes calls start after reset; each change lands just after a rising mclk edge.
`timescale 1ns/1ps
module dcf_host (
   input wire logic mclk,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [15:0] reg_wdata = 16'h0000,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d; // released data must not look like a valid word
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      int n;
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      n = 0;
      #1;
      while (reg_rvalid !== 1'b1 && n < 8) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n == 8) begin
         tb.err_count++;
         tb.results();
      end
      d = reg_rdata;
   endtask : rd
endmodule : dcf_host

// File: bench/dcf_monitor.sv
// dcf_monitor: port checks for the configuration bank.
// assumes it is bound into dcf_top; mirrors the clear select bit itself.
`timescale 1ns/1ps
module dcf_monitor (
   input logic mclk,
   input logic rstn,
   input logic ce,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_addr,
   input logic [15:0] reg_wdata,
   input logic reg_rvalid,
   input logic clear_req,
   input logic comparator_enable,
   input logic ch1_enable,
   input logic [9:0] cmp_sample,
   input logic [9:0] thr_upper,
   input logic [9:0] thr_lower,
   input logic [2:0] current_output_gain,
   input logic [1:0] comparator_threshold_mode,
   input logic [1:0] waveform_phase_select,
   input logic [2:0] waveform_shape_select,
   input logic [9:0] ch0_out_code,
   input logic cmp_out
);
   logic clr_q;
   wire wgain = ce && reg_wr && reg_addr == 8'h03;
   wire wmode = ce && reg_wr && reg_addr == 8'h17;
   wire wfunc = ce && reg_wr && reg_addr == 8'h12;
   wire in_win = thr_lower <= cmp_sample && cmp_sample <= thr_upper;
   wire cmp_on = comparator_enable && ch1_enable;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         clr_q <= 1'b0;
      end else if (wfunc) begin
         clr_q <= reg_wdata[15];
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_rvalid; ce && reg_rd |=> reg_rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_gain; wgain |=> current_output_gain == $past(reg_wdata[12:10]); endproperty
   a_gain: assert property (p_gain) else $error("gain field not taken");
   property p_mode; wmode |=> comparator_threshold_mode == $past(reg_wdata[11:10]); endproperty
   a_mode: assert property (p_mode) else $error("mode field not taken");
   property p_phase; wfunc |=> waveform_phase_select == $past(reg_wdata[12:11]); endproperty
   a_phase: assert property (p_phase) else $error("phase field not taken");
   property p_shape; wfunc |=> waveform_shape_select == $past(reg_wdata[10:8]); endproperty
   a_shape: assert property (p_shape) else $error("shape field not taken");
   property p_clear; ce && clear_req && !wfunc |=> ch0_out_code == (clr_q ? 10'h200 : 10'h000);
   endproperty
   a_clear: assert property (p_clear) else $error("wrong clear level");
   property p_cmpoff; ce && !cmp_on |=> !cmp_out; endproperty
   a_cmpoff: assert property (p_cmpoff) else $error("comparator active while off");
   property p_window; ce && cmp_on && comparator_threshold_mode == 2'b10 |=> cmp_out == $past(in_win);
   endproperty
   a_window: assert property (p_window) else $error("window result wrong");
endmodule : dcf_monitor

bind dcf_top dcf_monitor u_mon (.*);

// File: bench/tb.sv
// tb: host-model stimulus with reference checks on registers, comparator and channel 0.
// assumes every step interval is shortened to 4 cycles.
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic ch0_code_wr = 1'b0, bcast_wr = 1'b0, trigger_bit_wr = 1'b0, clear_req = 1'b0;
   logic load_trigger = 1'b1, comparator_enable = 1'b1, ch1_enable = 1'b1;
   logic [9:0] ch0_code = 10'h000, bcast_code = 10'h000, cmp_sample = 10'h000, ch0_out_code;
   logic [9:0] thr_upper = 10'h0c8, thr_lower = 10'h064;
   logic reg_wr, reg_rd, reg_rvalid, ch0_slewing, cmp_out;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [2:0] current_output_gain, waveform_shape_select;
   logic [1:0] comparator_threshold_mode, waveform_phase_select;
   int err_count = 0, checked = 0, seed = 32'hd5df18c2, h, v, p, n;
   int sz [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
   int shp [5] = '{0, 1, 2, 4, 7};
   int kd [8] = '{3, 3, 0, 0, 2, 4, 1, 1};
   logic [7:0] ad [4] = '{8'h03, 8'h12, 8'h17, 8'h55};
   logic [15:0] fn [8] = '{16'h8700, 16'h0700, 16'h0700, 16'h4700, 16'h4700, 16'h4700,
      16'h0700, 16'h2700};
   logic [9:0] cd [8] = '{10'h000, 10'h000, 10'h2a5, 10'h11b, 10'h000, 10'h3c7, 10'h055,
      10'h055};
   logic [9:0] ex [8] = '{10'h200, 10'h000, 10'h2a5, 10'h2a5, 10'h11b, 10'h3c7, 10'h3c7,
      10'h055};
   always #2 mclk = ~mclk;
   dcf_host host (.*);
   dcf_top #(.STEP_CYC('{default: 22'h4})) dut (.*);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   // kind 0 code write, 1 broadcast, 2 trigger bit, 3 clear
   task automatic cmd(input int k, input logic [9:0] c);
      @(posedge mclk);
      ch0_code_wr <= k == 0;
      bcast_wr <= k == 1;
      trigger_bit_wr <= k == 2;
      clear_req <= k == 3;
      ch0_code <= c;
      bcast_code <= c;
      @(posedge mclk);
      {ch0_code_wr, bcast_wr, trigger_bit_wr, clear_req} <= 4'h0;
   endtask : cmd
   task automatic settle();
      repeat (6) @(posedge mclk);
      for (n = 0; ch0_slewing !== 1'b0; n++) begin
         if (n == 3000) begin
            err_count++;
            results();
         end
         @(posedge mclk);
      end
      #1;
   endtask : settle
   initial begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      foreach (ad[i]) begin
         host.rd(ad[i], rv);
         check(rv, 16'h0000);
      end
      host.wr(8'h55, 16'hffff);
      host.wr(8'h03, 16'he7ff);
      host.rd(8'h03, rv);
      check(rv, 16'h0400);
      check(current_output_gain, 16'h0001);
      host.rd(8'h55, rv);
      check(rv, 16'h0000);
      $display("registers done");
      for (int md = 0; md < 3; md++) begin
         host.wr(8'h17, 16'hf3ff | 16'(md << 10));
         host.rd(8'h17, rv);
         check(rv, 16'(md << 10));
         h = 0;
         for (int i = 0; i < 24; i++) begin
            v = i == 0 ? 0 : $unsigned($random(seed)) % 301;
            @(posedge mclk);
            cmp_sample <= 10'(v);
            @(posedge mclk);
            #1;
            if (v > 200) h = 1;
            else if (v < 100) h = 0;
            check(cmp_out, md == 0 ? v > 200 : md == 1 ? h : v >= 100 && v <= 200);
         end
      end
      ch1_enable <= 1'b0;
      $display("comparator done");
      foreach (shp[i]) begin
         v = (i % 4) << 11 | shp[i] << 8 | ($random(seed) & 16'he0f0) | 1;
         host.wr(8'h12, 16'(v));
         host.rd(8'h12, rv);
         check(rv, 16'(v));
         check(waveform_phase_select, 16'(i % 4));
         check(waveform_shape_select, 16'(shp[i]));
      end
      $display("fields done");
      foreach (kd[i]) begin
         host.wr(8'h12, fn[i]);
         cmd(kd[i] == 4 ? 0 : kd[i], cd[i]);
         if (kd[i] == 4) load_trigger <= 1'b0;
         settle();
         load_trigger <= 1'b1;
         check(ch0_out_code, ex[i]);
      end
      $display("updates done");
      foreach (sz[k]) begin
         host.wr(8'h12, 16'h0701 | 16'(k << 4));
         cmd(3, 10'h000);
         settle();
         cmd(0, 10'h064);
         p = 0;
         for (n = 0; n < 2000 && (n < 3 || ch0_slewing === 1'b1); n++) begin
            @(posedge mclk);
            #1;
            if (ch0_out_code !== 10'(p)) begin
               check(ch0_out_code - 10'(p), 16'(100 - p < sz[k] ? 100 - p : sz[k]));
               p = ch0_out_code;
            end
         end
         settle();
         check(ch0_out_code, 10'h064);
      end
      $display("slew done");
      results();
   end
endmodule : tb
